// *** src/apm_pkg.sv ***
// Package with constants, types and helpers for the converter pin-mode control
package apm_pkg;

  // Register byte offsets
  localparam logic [7:0] APM_STATUS_OFF = 8'h00;
  localparam logic [7:0] APM_IRQ_STAT_OFF = 8'h04;
  localparam logic [7:0] APM_IRQ_CLR_OFF = 8'h08;
  localparam logic [7:0] APM_IRQ_EN_OFF = 8'h0c;
  localparam logic [7:0] APM_CTRL_OFF = 8'h10;
  localparam logic [7:0] APM_SER_WORD_OFF = 8'h14;

  // Status register bit positions
  localparam int APM_ST_CAL = 0;
  localparam int APM_ST_PD = 1;
  localparam int APM_ST_PDQ = 2;
  localparam int APM_ST_DES = 3;
  localparam int APM_ST_FSR_HI = 4;
  localparam int APM_ST_EXT = 5;
  localparam int APM_ST_DIFF = 6;

  // Interrupt event bit positions
  localparam int APM_EV_CAL_DONE = 0;
  localparam int APM_EV_RESYNC = 1;
  localparam int APM_EV_SER_WORD = 2;
  localparam int APM_EV_PD = 3;
  localparam int APM_EV_W = 4;

  // Control register bit positions and reset value
  localparam int APM_CT_FSR_HI = 0;
  localparam int APM_CT_CAL_GO = 1;
  localparam logic [1:0] APM_CTRL_RST = 2'h1;

  // Timing counts in clk cycles, serial word length in bits
  localparam int APM_TRIG_LOW_MIN = 80;
  localparam int APM_TRIG_HIGH_MIN = 80;
  localparam int APM_CAL_RUN_CYCLES = 1024;
  localparam int APM_SER_BITS = 16;

  // AXI response codes
  localparam logic [1:0] APM_RESP_OKAY = 2'h0;
  localparam logic [1:0] APM_RESP_SLVERR = 2'h2;

  // Tri-level pin encoding at the port
  localparam logic [1:0] APM_LVL_LOW = 2'h0;
  localparam logic [1:0] APM_LVL_MID = 2'h1;
  localparam logic [1:0] APM_LVL_HIGH = 2'h2;

  typedef struct packed {
    logic lo;
    logic mid;
    logic hi;
  } apm_tri_t;

  typedef struct packed {
    logic ext_mode;
    logic diff_resync;
    logic fsr_high;
    logic des_mode;
  } apm_mode_t;

  // Decodes a tri-level code into one-hot mode bits; unused code reads as high
  function automatic apm_tri_t apm_tri_decode(input logic [1:0] code);
    apm_tri_t t;
    t.lo = (code == APM_LVL_LOW);
    t.mid = (code == APM_LVL_MID);
    t.hi = !(t.lo || t.mid);
    return t;
  endfunction

endpackage

// *** src/apm_pin_mode_control.sv ***
// Pin-mode control logic of a dual-channel converter with AXI4-Lite status and control
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Single-ended or mid select: positive reset pulse resynchronises output data clock.
// - Differential select: reset pin is positive leg, range pin negative leg.
// - Power-down input high powers down the whole converter, both channels.
// - Trigger low for minimum cycles then high for minimum cycles starts calibration.
// - Calibration-active flag is high exactly while calibration runs.
// - Range pin acts only with select and pin-control high; low reduced, high higher.
// - Differential reset mode ignores range pin and defaults to higher range.
// - With extended control active, dual-edge pin becomes serial chip enable.
// - Pin-control with mid dual-edge pin: I sampled at twice rate, Q ignored.
// - Each sample is taken on the falling edge of positive input clock leg; in dual-edge mode I also samples on the rising edge.
// - Enable input low selects extended control; high restricts to pins, overriding.
// - In extended control, output-amplitude pin clocks serial data in.
module apm_pin_mode_control
  import apm_pkg::*;
#(
  parameter int TRIG_LOW_MIN = APM_TRIG_LOW_MIN,
  parameter int TRIG_HIGH_MIN = APM_TRIG_HIGH_MIN,
  parameter int CAL_RUN_CYCLES = APM_CAL_RUN_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] clock_resync_style_select,
  input wire logic output_clock_resync,
  input wire logic full_scale_range_select,
  input wire logic device_powerdown_in,
  input wire logic q_channel_powerdown_in,
  input wire logic cal_trigger,
  input wire logic extended_control_enable_n,
  input wire logic [1:0] dual_edge_select,
  input wire logic output_amplitude_select,
  input wire logic serial_shift_data,
  input wire logic sample_clk_p,
  output logic calibration_active_flag,
  output logic output_data_clock,
  output logic powerdown_all,
  output logic powerdown_q,
  output logic full_scale_high,
  output logic des_mode,
  output logic serial_chip_enable,
  output logic i_sample_strobe,
  output logic q_sample_strobe,
  output logic irq
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_ARMED, CAL_HIGH, CAL_RUN} apm_cal_t;

  localparam logic [15:0] LOW_MIN = 16'(TRIG_LOW_MIN);
  localparam logic [15:0] HIGH_MIN = 16'(TRIG_HIGH_MIN);
  localparam logic [15:0] RUN_LAST = 16'(CAL_RUN_CYCLES - 1);
  localparam logic [4:0] SER_LAST = 5'(APM_SER_BITS - 1);

  apm_cal_t cal_r, cal_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  apm_mode_t mode_r;
  logic [1:0] ctrl_r;
  logic cal_go_r;
  logic [APM_EV_W-1:0] irq_stat_r, irq_en_r;
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic resync_prev_r, sclk_prev_r, sclk_in_prev_r, pd_prev_r, odc_r;
  logic [15:0] ser_shift_r, ser_word_r;
  logic [4:0] ser_cnt_r;
  logic i_strobe_r, q_strobe_r;

  // Tri-level pin decode into one-hot level bits
  apm_tri_t style_lvl, des_lvl;
  assign style_lvl = apm_tri_decode(clock_resync_style_select);
  assign des_lvl = apm_tri_decode(dual_edge_select);

  // Mode selection from the decoded pins
  apm_mode_t mode_nxt;
  assign mode_nxt.ext_mode = !extended_control_enable_n;
  assign mode_nxt.diff_resync = style_lvl.lo;
  assign mode_nxt.des_mode = extended_control_enable_n && des_lvl.mid;
  // Range pin only counts with high select in pin control; else default or register
  assign mode_nxt.fsr_high = (style_lvl.hi && extended_control_enable_n) ?
                             full_scale_range_select :
                             (style_lvl.lo || extended_control_enable_n) ? 1'b1 :
                             ctrl_r[APM_CT_FSR_HI];

  // Resync pulse detection for both pin styles
  logic resync_lvl, resync_evt;
  assign resync_lvl = style_lvl.lo ? (output_clock_resync && !full_scale_range_select)
                                   : output_clock_resync;
  assign resync_evt = resync_lvl && !resync_prev_r;

  // Sample clock edges on the positive leg
  logic samp_fall, samp_rise;
  assign samp_fall = sclk_prev_r && !sample_clk_p;
  assign samp_rise = !sclk_prev_r && sample_clk_p;

  // Serial port: chip enable active low on the dual-edge pin in extended control
  logic ser_sel, ser_edge, ser_done;
  assign ser_sel = mode_r.ext_mode && des_lvl.lo;
  assign ser_edge = ser_sel && output_amplitude_select && !sclk_in_prev_r;
  assign ser_done = ser_edge && (ser_cnt_r == SER_LAST);

  // Calibration trigger qualifier and run sequencer
  logic cal_done;
  always_comb
  begin
    cal_nxt = cal_r;
    cnt_nxt = cnt_r;
    cal_done = 1'b0;
    unique case (cal_r)
      CAL_IDLE:
      begin
        if (cal_trigger)
          cnt_nxt = '0;
        else if (cnt_r >= LOW_MIN - 16'h0001)
          cal_nxt = CAL_ARMED;
        else
          cnt_nxt = cnt_r + 16'h0001;
        if (cal_go_r)
        begin
          cal_nxt = CAL_RUN;
          cnt_nxt = '0;
        end
      end
      CAL_ARMED:
      begin
        if (cal_trigger)
        begin
          cal_nxt = CAL_HIGH;
          cnt_nxt = 16'h0001;
        end
        if (cal_go_r)
        begin
          cal_nxt = CAL_RUN;
          cnt_nxt = '0;
        end
      end
      CAL_HIGH:
      begin
        if (!cal_trigger)
        begin
          cal_nxt = CAL_IDLE;
          cnt_nxt = 16'h0001;
        end
        else if (cnt_r >= HIGH_MIN - 16'h0001)
        begin
          cal_nxt = CAL_RUN;
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      CAL_RUN:
      begin
        if (cnt_r == RUN_LAST)
        begin
          cal_nxt = CAL_IDLE;
          cnt_nxt = '0;
          cal_done = 1'b1;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cal_r <= CAL_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      cal_r <= cal_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Pin history, mode latch and output data clock divider
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= '0;
      resync_prev_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      sclk_in_prev_r <= 1'b0;
      pd_prev_r <= 1'b0;
      odc_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      resync_prev_r <= resync_lvl;
      sclk_prev_r <= sample_clk_p;
      sclk_in_prev_r <= output_amplitude_select;
      pd_prev_r <= device_powerdown_in;
      odc_r <= (resync_evt || device_powerdown_in) ? 1'b0 : !odc_r;
    end
  end

  // Sample strobes per channel, suppressed by power down
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      i_strobe_r <= 1'b0;
      q_strobe_r <= 1'b0;
    end
    else
    begin
      i_strobe_r <= !device_powerdown_in && (samp_fall || (mode_r.des_mode && samp_rise));
      q_strobe_r <= !device_powerdown_in && !q_channel_powerdown_in &&
                    !mode_r.des_mode && samp_fall;
    end
  end

  // Serial shift register clocked by the output-amplitude pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ser_shift_r <= '0;
      ser_cnt_r <= '0;
      ser_word_r <= '0;
    end
    else
    begin
      if (!ser_sel)
        ser_cnt_r <= '0;
      else if (ser_edge)
      begin
        ser_shift_r <= {ser_shift_r[14:0], serial_shift_data};
        ser_cnt_r <= ser_done ? 5'h00 : ser_cnt_r + 5'h01;
      end
      if (ser_done)
        ser_word_r <= {ser_shift_r[14:0], serial_shift_data};
    end
  end

  // AXI write decode
  logic aw_take, w_take, do_write, do_read, wr_hit, rd_hit, lane0;
  logic [APM_EV_W-1:0] events, irq_clr;
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign lane0 = w_strb_r[0];
  assign wr_hit = (aw_addr_r == APM_IRQ_CLR_OFF) || (aw_addr_r == APM_IRQ_EN_OFF) ||
                  (aw_addr_r == APM_CTRL_OFF);
  assign irq_clr = (do_write && lane0 && aw_addr_r == APM_IRQ_CLR_OFF) ?
                   w_data_r[APM_EV_W-1:0] : '0;

  // Event collection and interrupt output
  assign events[APM_EV_CAL_DONE] = cal_done;
  assign events[APM_EV_RESYNC] = resync_evt;
  assign events[APM_EV_SER_WORD] = ser_done;
  assign events[APM_EV_PD] = device_powerdown_in && !pd_prev_r;
  assign irq = |(irq_stat_r & irq_en_r);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= APM_RESP_OKAY;
      irq_en_r <= '0;
      irq_stat_r <= '0;
      ctrl_r <= APM_CTRL_RST;
      cal_go_r <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      cal_go_r <= 1'b0;
      if (do_write)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? APM_RESP_OKAY : APM_RESP_SLVERR;
        if (lane0 && aw_addr_r == APM_IRQ_EN_OFF)
          irq_en_r <= w_data_r[APM_EV_W-1:0];
        if (lane0 && aw_addr_r == APM_CTRL_OFF)
        begin
          ctrl_r[APM_CT_FSR_HI] <= w_data_r[APM_CT_FSR_HI];
          cal_go_r <= w_data_r[APM_CT_CAL_GO];
        end
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | events; // Set wins over clear
    end
  end

  // AXI read path
  logic [31:0] rd_mux;
  logic [7:0] rd_addr;
  logic [6:0] status_bits;
  assign s_axi_arready = !rvalid_r;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign status_bits[APM_ST_CAL] = calibration_active_flag;
  assign status_bits[APM_ST_PD] = device_powerdown_in;
  assign status_bits[APM_ST_PDQ] = q_channel_powerdown_in;
  assign status_bits[APM_ST_DES] = mode_r.des_mode;
  assign status_bits[APM_ST_FSR_HI] = mode_r.fsr_high;
  assign status_bits[APM_ST_EXT] = mode_r.ext_mode;
  assign status_bits[APM_ST_DIFF] = mode_r.diff_resync;
  assign rd_hit = (rd_addr == APM_STATUS_OFF) || (rd_addr == APM_IRQ_STAT_OFF) ||
                  (rd_addr == APM_IRQ_CLR_OFF) || (rd_addr == APM_IRQ_EN_OFF) ||
                  (rd_addr == APM_CTRL_OFF) || (rd_addr == APM_SER_WORD_OFF);
  assign rd_mux = (rd_addr == APM_STATUS_OFF) ? {25'h0, status_bits} :
                  (rd_addr == APM_IRQ_STAT_OFF) ? {28'h0, irq_stat_r} :
                  (rd_addr == APM_IRQ_EN_OFF) ? {28'h0, irq_en_r} :
                  (rd_addr == APM_CTRL_OFF) ? {30'h0, 1'b0, ctrl_r[APM_CT_FSR_HI]} :
                  (rd_addr == APM_SER_WORD_OFF) ? {16'h0, ser_word_r} : 32'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= APM_RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? APM_RESP_OKAY : APM_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Output drive
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign calibration_active_flag = (cal_r == CAL_RUN);
  assign output_data_clock = odc_r;
  assign powerdown_all = device_powerdown_in;
  assign powerdown_q = device_powerdown_in || q_channel_powerdown_in;
  assign full_scale_high = mode_r.fsr_high;
  assign des_mode = mode_r.des_mode;
  assign serial_chip_enable = ser_sel;
  assign i_sample_strobe = i_strobe_r;
  assign q_sample_strobe = q_strobe_r;

endmodule

// *** dv/apm_pin_mode_control_asserts.sv ***
// Concurrent checks on the pin-mode control ports
`timescale 1ns/1ps
module apm_pin_mode_control_asserts
  import apm_pkg::*;
#(
  parameter int CAL_RUN_CYCLES = APM_CAL_RUN_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] clock_resync_style_select,
  input wire logic full_scale_range_select,
  input wire logic device_powerdown_in,
  input wire logic q_channel_powerdown_in,
  input wire logic extended_control_enable_n,
  input wire logic [1:0] dual_edge_select,
  input wire logic sample_clk_p,
  input wire logic calibration_active_flag,
  input wire logic output_data_clock,
  input wire logic powerdown_all,
  input wire logic powerdown_q,
  input wire logic full_scale_high,
  input wire logic des_mode,
  input wire logic serial_chip_enable,
  input wire logic i_sample_strobe,
  input wire logic q_sample_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Length of the current run of the calibration flag
  logic [15:0] run_cnt_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_cnt_r <= 16'h0;
    else if (calibration_active_flag)
      run_cnt_r <= run_cnt_r + 16'h1;
    else
      run_cnt_r <= 16'h0;
  end
  // Mode outputs follow the pins one cycle later, power-down outputs and the chip enable's dual-edge pin term at once; strobes follow input clock edges
  property p_pd_whole;
    powerdown_all == device_powerdown_in &&
      powerdown_q == (device_powerdown_in || q_channel_powerdown_in);
  endproperty
  a_pd_whole: assert property (p_pd_whole) else $error("power-down outputs wrong");
  property p_odc_pd;
    device_powerdown_in |=> !output_data_clock;
  endproperty
  a_odc_pd: assert property (p_odc_pd) else $error("data clock runs in power down");
  property p_cal_len;
    $fell(calibration_active_flag) |-> run_cnt_r == CAL_RUN_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration run length wrong");
  property p_range_pin;
    !$past(rst) && $past(clock_resync_style_select) == APM_LVL_HIGH &&
      $past(extended_control_enable_n) |-> full_scale_high == $past(full_scale_range_select);
  endproperty
  a_range_pin: assert property (p_range_pin) else $error("range pin not followed");
  property p_range_diff;
    !$past(rst) && $past(clock_resync_style_select) == APM_LVL_LOW |-> full_scale_high;
  endproperty
  a_range_diff: assert property (p_range_diff) else $error("range not high in diff mode");
  property p_chip_en;
    !$past(rst) |-> serial_chip_enable ==
      (!$past(extended_control_enable_n) && dual_edge_select == APM_LVL_LOW);
  endproperty
  a_chip_en: assert property (p_chip_en) else $error("serial chip enable wrong");
  property p_des;
    !$past(rst) |-> des_mode ==
      ($past(extended_control_enable_n) && $past(dual_edge_select) == APM_LVL_MID);
  endproperty
  a_des: assert property (p_des) else $error("dual-edge mode wrong");
  property p_q_ignored;
    $past(des_mode) && $past(des_mode, 2) |-> !q_sample_strobe;
  endproperty
  a_q_ignored: assert property (p_q_ignored) else $error("q strobe in dual-edge mode");
  property p_fall_strobe;
    !$past(rst) && !$past(rst, 2) && !device_powerdown_in && $fell(sample_clk_p) |->
      ##[1:3] i_sample_strobe;
  endproperty
  a_fall_strobe: assert property (p_fall_strobe) else $error("no strobe after fall");
endmodule

bind apm_pin_mode_control apm_pin_mode_control_asserts #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES))
  u_apm_pin_mode_control_asserts (.clk, .rst, .clock_resync_style_select,
  .full_scale_range_select, .device_powerdown_in, .q_channel_powerdown_in,
  .extended_control_enable_n, .dual_edge_select, .sample_clk_p, .calibration_active_flag,
  .output_data_clock,
  .powerdown_all, .powerdown_q, .full_scale_high, .des_mode, .serial_chip_enable,
  .i_sample_strobe, .q_sample_strobe);

// *** dv/apm_ctrl_model.sv ***
// Controller model driving input clock, calibration trigger and serial lines
`timescale 1ns/1ps
module apm_ctrl_model
  import apm_pkg::*;
(
  input wire logic clk,
  output logic sample_clk_p,
  output logic cal_trigger,
  output logic output_amplitude_select,
  output logic serial_shift_data
);
  // Input clock runs free, six clk cycles per period
  initial
  begin
    sample_clk_p = 1'b0;
    cal_trigger = 1'b0;
    output_amplitude_select = 1'b0;
    serial_shift_data = 1'b0;
    forever
    begin
      repeat (3) @(posedge clk);
      sample_clk_p <= !sample_clk_p;
    end
  end
  // One high cycle, then lo cycles low and hi cycles high, then low again
  task automatic cal_pulse(input int lo, input int hi);
    @(posedge clk);
    cal_trigger <= 1'b1;
    @(posedge clk);
    cal_trigger <= 1'b0;
    repeat (lo) @(posedge clk);
    cal_trigger <= 1'b1;
    repeat (hi) @(posedge clk);
    cal_trigger <= 1'b0;
  endtask
  // Word shifted MSB first; clock idles low and data is inverted after the frame
  task automatic ser_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk);
      serial_shift_data <= w[i];
      repeat (2) @(posedge clk);
      output_amplitude_select <= 1'b1;
      repeat (2) @(posedge clk);
      output_amplitude_select <= 1'b0;
    end
    @(posedge clk);
    serial_shift_data <= !w[0];
  endtask
endmodule

// *** dv/apm_pin_mode_control_test.sv ***
// Self-checking testbench for the pin-mode control block
`timescale 1ns/1ps
module apm_pin_mode_control_test
  import apm_pkg::*;
();
  localparam int LMIN = 4;
  localparam int HMIN = 4;
  localparam int RUNC = 16;
  // Resync cases: style, range pin (FS), event expected (EV), range output (FH)
  localparam logic [1:0] ST [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic [4:0] FS = 5'h09;
  localparam logic [4:0] EV = 5'h17;
  localparam logic [4:0] FH = 5'h1d;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, clock_resync_style_select, dual_edge_select;
  logic output_clock_resync, full_scale_range_select, device_powerdown_in;
  logic q_channel_powerdown_in, cal_trigger, extended_control_enable_n, sample_clk_p;
  logic output_amplitude_select, serial_shift_data, calibration_active_flag, irq;
  logic output_data_clock, powerdown_all, powerdown_q, full_scale_high, des_mode;
  logic serial_chip_enable, i_sample_strobe, q_sample_strobe;
  int fails, checks;

  apm_pin_mode_control #(.TRIG_LOW_MIN(LMIN), .TRIG_HIGH_MIN(HMIN), .CAL_RUN_CYCLES(RUNC))
    u_apm_pin_mode_control (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_resync_style_select,
    .output_clock_resync, .full_scale_range_select, .device_powerdown_in,
    .q_channel_powerdown_in, .cal_trigger, .extended_control_enable_n, .dual_edge_select,
    .output_amplitude_select, .serial_shift_data, .sample_clk_p, .calibration_active_flag,
    .output_data_clock, .powerdown_all, .powerdown_q, .full_scale_high, .des_mode,
    .serial_chip_enable, .i_sample_strobe, .q_sample_strobe, .irq);

  apm_ctrl_model u_apm_ctrl_model (.clk, .sample_clk_p, .cal_trigger,
    .output_amplitude_select, .serial_shift_data);

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Write with address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic pins(input logic [1:0] st, input logic fs, input logic en_n,
    input logic [1:0] de, input logic pd);
    @(posedge clk);
    clock_resync_style_select <= st;
    full_scale_range_select <= fs;
    extended_control_enable_n <= en_n;
    dual_edge_select <= de;
    device_powerdown_in <= pd;
    repeat (4) @(posedge clk);
  endtask

  // Trigger pulse, or software start when hi is zero, while counting flag cycles
  task automatic cal(input int lo, input int hi, input int e);
    int n;
    n = 0;
    fork
      if (hi > 0)
        u_apm_ctrl_model.cal_pulse(lo, hi);
      else
        wr(APM_CTRL_OFF, 32'h3, APM_RESP_OKAY);
      repeat (40)
      begin
        @(posedge clk);
        n += int'(calibration_active_flag === 1'b1);
      end
    join
    chk(n, e);
  endtask

  task automatic strobes(input int ei, input int eq);
    int ni, nq;
    ni = 0;
    nq = 0;
    repeat (24)
    begin
      @(posedge clk);
      ni += int'(i_sample_strobe === 1'b1);
      nq += int'(q_sample_strobe === 1'b1);
    end
    if (ei >= 0)
      chk(ni, ei);
    chk(nq, eq);
  endtask

  task automatic irq_chk(input logic [31:0] e);
    rd(APM_IRQ_STAT_OFF, e, APM_RESP_OKAY);
    chk({31'h0, irq}, {31'h0, |e});
    wr(APM_IRQ_CLR_OFF, e, APM_RESP_OKAY);
  endtask

  task automatic end_sim();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 8'h0, 32'h0, 4'h0};
    {clock_resync_style_select, dual_edge_select} = {APM_LVL_HIGH, APM_LVL_HIGH};
    {full_scale_range_select, extended_control_enable_n} = 2'h3;
    {output_clock_resync, device_powerdown_in, q_channel_powerdown_in} = 3'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr(APM_IRQ_EN_OFF, 32'hf, APM_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(APM_IRQ_EN_OFF, 32'h0, APM_RESP_OKAY);
    rd(APM_CTRL_OFF, 32'h1, APM_RESP_OKAY);
    rd(APM_STATUS_OFF, 32'h10, APM_RESP_OKAY);
    rd(8'h18, 32'h0, APM_RESP_SLVERR);
    wr(8'h18, 32'h3, APM_RESP_SLVERR);
    // Calibration: exact phases, masked then enabled interrupt, short phases, software start
    cal(LMIN, HMIN, RUNC);
    chk({31'h0, irq}, 32'h0);
    wr(APM_IRQ_EN_OFF, 32'hf, APM_RESP_OKAY);
    irq_chk(32'h1);
    cal(LMIN - 1, HMIN, 0);
    cal(LMIN, HMIN - 1, 0);
    cal(0, 0, RUNC);
    rd(APM_CTRL_OFF, 32'h1, APM_RESP_OKAY);
    irq_chk(32'h1);
    // Resync and range per style
    for (int k = 0; k < 5; k++)
    begin
      pins(ST[k], FS[k], 1'b1, APM_LVL_HIGH, 1'b0);
      chk({31'h0, full_scale_high}, {31'h0, FH[k]});
      output_clock_resync <= 1'b1;
      repeat (2) @(posedge clk);
      output_clock_resync <= 1'b0;
      if (EV[k])
        chk({31'h0, output_data_clock}, 32'h0);
      repeat (3) @(posedge clk);
      irq_chk({30'h0, EV[k], 1'b0});
    end
    // Extended control: range from control bit, serial chip enable and shifting
    pins(APM_LVL_HIGH, 1'b0, 1'b0, APM_LVL_MID, 1'b0);
    chk({31'h0, des_mode}, 32'h0);
    chk({31'h0, serial_chip_enable}, 32'h0);
    pins(APM_LVL_HIGH, 1'b0, 1'b0, APM_LVL_LOW, 1'b0);
    chk({31'h0, serial_chip_enable}, 32'h1);
    rd(APM_STATUS_OFF, 32'h30, APM_RESP_OKAY);
    u_apm_ctrl_model.ser_word(16'ha5c3);
    rd(APM_SER_WORD_OFF, 32'ha5c3, APM_RESP_OKAY);
    irq_chk(32'h4);
    wr(APM_CTRL_OFF, 32'h0, APM_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, full_scale_high}, 32'h0);
    // Sampling edges: dual-edge, normal, power-down
    pins(APM_LVL_HIGH, 1'b1, 1'b1, APM_LVL_MID, 1'b0);
    strobes(8, 0);
    pins(APM_LVL_HIGH, 1'b1, 1'b1, APM_LVL_HIGH, 1'b0);
    strobes(4, 4);
    q_channel_powerdown_in <= 1'b1;
    @(posedge clk);
    strobes(4, 0);
    pins(APM_LVL_HIGH, 1'b1, 1'b1, APM_LVL_HIGH, 1'b1);
    chk({30'h0, powerdown_all, powerdown_q}, 32'h3);
    strobes(0, 0);
    irq_chk(32'h8);
    end_sim();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule
